// ---- common/adcf_pkg.sv ----
// adcf_pkg: constants and types shared by the adc capture framework
// assumes a 125 MHz system clock and a 14-bit ddr adc bus
package adcf_pkg;

    // data bus and calibration number formats
    localparam int          ADC_WIDTH   = 14;
    localparam int          GAIN_WIDTH  = 18;
    localparam int          GAIN_FRAC   = 16;
    localparam logic [17:0] GAIN_UNITY  = 18'h10000;   // 1.0 in two-integer-bit format

    // system clock and link timing
    localparam int CLK_PERIOD_PS       = 8000;
    localparam int DCLK_MIN_MHZ        = 10;
    localparam int DCLK_MAX_PERIOD_PS  = 1000000 / DCLK_MIN_MHZ;
    // longest wait for a data clock edge: rounds down, at least one cycle
    localparam int DCLK_WATCH_CYC      = (DCLK_MAX_PERIOD_PS / CLK_PERIOD_PS < 1) ? 1 :
                                         DCLK_MAX_PERIOD_PS / CLK_PERIOD_PS;
    localparam logic [4:0] DCLK_WATCH_MAX = 5'(DCLK_WATCH_CYC);

    // configuration sequence lengths in system cycles
    localparam logic [5:0] ADC_CFG_CYC = 6'h10;
    localparam logic [5:0] GEN_CFG_CYC = 6'h10;

    // clock domain indices for the reset bridges
    localparam int DOM_SYS  = 0;
    localparam int DOM_REF  = 1;
    localparam int DOM_DIO  = 2;    // io-local data clock
    localparam int DOM_DGL  = 3;    // global data clock
    localparam int DOM_NUM  = 4;

    // preset sampling rates in kHz, index 0..6
    localparam int          RATE_NUM     = 7;
    localparam logic [2:0]  RATE_DEFAULT = 3'h6;
    function automatic logic [17:0] rate_khz(input logic [2:0] idx);
        case (idx)
            3'h0:    rate_khz = 18'd50000;
            3'h1:    rate_khz = 18'd80000;
            3'h2:    rate_khz = 18'd100000;
            3'h3:    rate_khz = 18'd110000;
            3'h4:    rate_khz = 18'd120000;
            3'h5:    rate_khz = 18'd122880;
            default: rate_khz = 18'd125000;
        endcase
    endfunction

    // configuration sequencer states
    typedef enum logic [1:0] {
        ST_WAIT    = 2'b00,
        ST_ADC_CFG = 2'b01,
        ST_GEN_CFG = 2'b10,
        ST_DONE    = 2'b11
    } adcf_state_t;

endpackage

// ---- dv/adcf_adc_model.sv ----
// adcf_adc_model: behavioural dual-channel adc with a ddr output bus
// assumes the bench calls send_pair; the data clock rests low between calls
`timescale 1ns/1ps
`default_nettype none

module adcf_adc_model
    import adcf_pkg::*;
(
    output logic                 o_dclk,
    output logic [ADC_WIDTH-1:0] o_data
);
    // one 160 ns clock period: a centred on the rise, b held from 40 ns before the fall to 20 ns after it
    task automatic send_pair(input logic [ADC_WIDTH-1:0] a, b);
        o_data = a;
        #40 o_dclk = 1'b1;
        #40 o_data = b;
        #40 o_dclk = 1'b0;
        #20 o_data = ~b;    // idle bus between pairs must not look like a held sample
        #20;
    endtask

    // quiet bus at start
    initial begin
        o_dclk = 1'b0;
        o_data = '0;
    end
endmodule // adcf_adc_model
`default_nettype wire

// ---- dv/tb_top.sv ----
// tb_top: self-checking bench of the adc capture frame
// assumes adcf_top and the adc model; reference clock made here
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import adcf_pkg::*;
;
    logic                  clk, rst_n, ref_clk, xtal, acq, rdy, dclk;
    logic                  ref_o, sel_o, adc_act, gen_act, done, busy, lost, ovr, vld;
    logic [2:0]            rate;
    logic [17:0]           rate_o;
    logic [GAIN_WIDTH-1:0] gain_a, gain_b;
    logic [ADC_WIDTH-1:0]  off_a, off_b, ch_a, ch_b, dat;
    int                    err_count, samples_checked;

    adcf_adc_model adc (.o_dclk(dclk), .o_data(dat));

    adcf_top DUT (
        .i_clk(clk), .i_rst_n(rst_n), .i_adc_data_clock_in(dclk), .i_adc_data(dat),
        .i_generator_primary_reference_clock(ref_clk), .i_use_crystal_reference(xtal),
        .i_rate_select(rate), .i_acquisition_enable(acq), .i_gain_a(gain_a),
        .i_gain_b(gain_b), .i_offset_a(off_a), .i_offset_b(off_b), .i_sample_ready(rdy),
        .o_generator_primary_reference_clock(ref_o), .o_generator_reference_select(sel_o),
        .o_generator_rate_khz(rate_o), .o_adc_config_active(adc_act),
        .o_generator_config_active(gen_act), .o_config_done(done),
        .o_reset_in_progress(busy), .o_data_clock_lost(lost), .o_overrun(ovr),
        .o_sample_valid(vld), .o_channel_a(ch_a), .o_channel_b(ch_b));

    // system clock and free-running reference clock
    always #4 clk = ~clk;
    always #48 ref_clk = ~ref_clk;

    task automatic check(input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    function automatic logic [31:0] exp_rate(input logic [2:0] r);
        case (r)
            3'h0: return 32'hc350;
            3'h1: return 32'h13880;
            3'h2: return 32'h186a0;
            3'h3: return 32'h1adb0;
            3'h4: return 32'h1d4c0;
            3'h5: return 32'h1e000;
            default: return 32'h1e848;
        endcase
    endfunction

    // wait a bounded time for one pair, compare it, ready pops it
    task automatic get_pair(input logic [ADC_WIDTH-1:0] a, b);
        int n;
        n = 0;
        @(negedge clk);
        while (vld !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        check({vld, ch_a, ch_b}, {1'b1, a, b});
    endtask

    // reset, wake every domain with idle pairs, check the bring-up sequence
    task automatic do_reset(input logic [2:0] r);
        int na, ng;
        na = 0;
        ng = 0;
        @(negedge clk);
        rst_n = 1'b0;
        acq = 1'b0;
        rate = r;
        repeat (40) @(negedge clk);
        check({busy, ref_o, done, vld, adc_act, ovr}, 6'h20);
        check(rate_o, 32'h1e848);
        rst_n = 1'b1;
        fork
            begin
                adc.send_pair('0, '0);
                check(busy, 1'b1);
                adc.send_pair('0, '0);
                adc.send_pair('0, '0);
            end
            repeat (70) begin
                @(negedge clk);
                na += int'(adc_act);
                ng += int'(gen_act);
            end
        join
        for (int n = 0; n < 200 && busy !== 1'b0; n++) @(negedge clk);
        check(busy, 1'b0);
        check(na, 32'h10);
        check(ng, 32'h10);
        check({done, rate_o}, {1'b1, 18'(exp_rate(r))});
    endtask

    // reference forwarded edge for edge; crystal select follows its input
    task automatic t_ref();
        int ci, co;
        logic li, lo;
        @(negedge clk);
        ci = 0;
        co = 0;
        li = ref_clk;
        lo = ref_o;
        xtal = 1'b1;
        repeat (200) begin
            @(negedge clk);
            ci += int'(ref_clk != li);
            co += int'(ref_o != lo);
            li = ref_clk;
            lo = ref_o;
        end
        check(32'(ci > co + 1 || co > ci + 1 || co == 0), 0);
        check(sel_o, 1'b1);
        xtal = 1'b0;
        repeat (4) @(negedge clk);
        check(sel_o, 1'b0);
    endtask

    // back-to-back pairs with boundary codes, unity gain
    task automatic t_stream();
        logic [ADC_WIDTH-1:0] v [4];
        v = '{14'h0000, 14'h1fff, 14'h2000, 14'h3fff};
        @(negedge clk);
        check(vld, 1'b0);
        acq = 1'b1;
        rdy = 1'b1;
        fork
            for (int i = 0; i < 4; i++) adc.send_pair(v[i], ~v[i]);
            for (int i = 0; i < 4; i++) get_pair(v[i], ~v[i]);
        join
    endtask

    // consumer stalls: two pairs held in order, the third dropped
    task automatic t_stall();
        @(negedge clk);
        rdy = 1'b0;
        adc.send_pair(14'h0111, 14'h0222);
        adc.send_pair(14'h0333, 14'h0444);
        adc.send_pair(14'h0555, 14'h0666);
        repeat (20) @(negedge clk);
        check({ovr, vld, ch_a, ch_b}, {2'b11, 14'h0111, 14'h0222});
        rdy = 1'b1;
        @(negedge clk);
        check({vld, ch_a, ch_b}, {1'b1, 14'h0333, 14'h0444});
        @(negedge clk);
        check(vld, 1'b0);
    endtask

    // half gain with offset on a, saturating offset on b
    task automatic t_gain();
        @(negedge clk);
        gain_a = 18'h08000;
        off_a = 14'h0010;
        off_b = 14'h0200;
        check(lost, 1'b1);
        fork
            begin
                adc.send_pair(14'h0100, 14'h1f00);
                adc.send_pair(14'h3f00, 14'h0000);
            end
            begin
                get_pair(14'h0090, 14'h1fff);
                get_pair(14'h3f90, 14'h0200);
            end
        join
        check(lost, 1'b0);
    endtask

    // main sequence, every input set at time zero
    initial begin
        {clk, ref_clk, rst_n, xtal, acq, rdy} = '0;
        rate = 3'h6;
        {gain_a, gain_b} = {GAIN_UNITY, GAIN_UNITY};
        {off_a, off_b} = '0;
        err_count = 0;
        samples_checked = 0;
        for (int r = 0; r < 8; r++) do_reset(3'(r));
        t_ref();
        t_stream();
        t_stall();
        t_gain();
        end_sim();
    end

    // watchdog, about ten times the expected run
    initial begin
        #100000;
        err_count++;
        end_sim();
    end
endmodule // tb_top
`default_nettype wire

// ---- src/adcf_top.sv ----
// adcf_top: clock, reset and capture frame of a dual-channel ddr adc controller
// assumes the adc data clock, reference clock and data bus arrive as pins
// sampled by i_clk; user-side controls are synchronous to i_clk
//
// Function
// RQ1: capture 14-bit ddr bus, channels on opposite edges
// RQ2: split into two single-rate channels for user
// RQ3: sampling rate is one of seven presets
// RQ4: four clock domains, each with reset synchroniser
// RQ5: system clock runs configuration and serial masters
// RQ6: reference domain only forwards reference clock out
// RQ7: data clock feeds capture and calibration paths
// RQ8: one active-low async reset clears all domains
// RQ9: per-domain reset asserts async, releases synchronously
// RQ10: user holds reset two slowest clock periods
// RQ11: reset-busy raised; no new reset until dropped
// RQ12: adc data clock not below 10 MHz
// RQ13: no clock synthesis, only reference pass-through
// RQ14: generator picks forwarded or crystal reference
// RQ15: write initial adc configuration after reset
// RQ16: program generator for selected preset frequency
// RQ17: apply user offset and gain correction
// RQ18: user keeps acquisition enable high once raised
// RQ19: valid flag qualifies both channel outputs
// RQ20: busy drops after every domain reset released
`timescale 1ns/1ps
`default_nettype none

module adcf_top
    import adcf_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_adc_data_clock_in,
    input  wire logic [ADC_WIDTH-1:0]  i_adc_data,
    input  wire logic                  i_generator_primary_reference_clock,
    input  wire logic                  i_use_crystal_reference,
    input  wire logic [2:0]            i_rate_select,
    input  wire logic                  i_acquisition_enable,
    input  wire logic [GAIN_WIDTH-1:0] i_gain_a,
    input  wire logic [GAIN_WIDTH-1:0] i_gain_b,
    input  wire logic [ADC_WIDTH-1:0]  i_offset_a,
    input  wire logic [ADC_WIDTH-1:0]  i_offset_b,
    input  wire logic                  i_sample_ready,
    output logic                       o_generator_primary_reference_clock,
    output logic                       o_generator_reference_select,
    output logic [17:0]                o_generator_rate_khz,
    output logic                       o_adc_config_active,
    output logic                       o_generator_config_active,
    output logic                       o_config_done,
    output logic                       o_reset_in_progress,
    output logic                       o_data_clock_lost,
    output logic                       o_overrun,
    output logic                       o_sample_valid,
    output logic [ADC_WIDTH-1:0]       o_channel_a,
    output logic [ADC_WIDTH-1:0]       o_channel_b
);

    localparam int ADC_WAIT_MAX = 17;
    localparam int SYS_REL_MAX  = 2;

    // offset and gain correction with saturation, shared by both channels
    function automatic logic [ADC_WIDTH-1:0] calib(input logic [ADC_WIDTH-1:0]  smp,
                                                   input logic [GAIN_WIDTH-1:0] gain,
                                                   input logic [ADC_WIDTH-1:0]  off);
        logic signed [31:0] prod;
        logic signed [17:0] sum;
        prod = 32'($signed(smp) * $signed(gain));
        sum  = 18'(prod >>> GAIN_FRAC) + 18'($signed(off));
        if (sum > 18'sd8191)
            calib = 14'h1fff;
        else if (sum < -18'sd8192)
            calib = 14'h2000;
        else
            calib = sum[ADC_WIDTH-1:0];
    endfunction

    logic [2:0]           dclk_sync_r;
    logic                 dclk_lvl_r;
    logic [2:0]           ref_sync_r;
    logic                 ref_lvl_r;
    logic [ADC_WIDTH-1:0] data_s1_r, data_s2_r, data_s3_r;
    logic                 dclk_rise, dclk_fall, ref_edge;
    logic [DOM_NUM-1:0]   rst_s1_r, rst_s2_r, dom_en;
    logic [4:0]           watch_r;
    adcf_state_t          state_r;
    logic [5:0]           cfg_cnt_r;
    logic [ADC_WIDTH-1:0] raw_a_r;
    logic                 have_a_r;
    logic                 push_w;
    logic [ADC_WIDTH-1:0] buf_a_r [2];
    logic [ADC_WIDTH-1:0] buf_b_r [2];
    logic                 wr_ptr_r, rd_ptr_r;
    logic [1:0]           count_r;
    logic                 pop_w;

    // three-stage synchronisers for link pins; stage one feeds only stage two
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dclk_sync_r <= 3'h0;
            ref_sync_r  <= 3'h0;
            data_s1_r   <= 14'h0;
            data_s2_r   <= 14'h0;
            data_s3_r   <= 14'h0;
        end else begin
            dclk_sync_r <= {dclk_sync_r[1:0], i_adc_data_clock_in};
            ref_sync_r  <= {ref_sync_r[1:0], i_generator_primary_reference_clock};
            data_s1_r   <= i_adc_data;
            data_s2_r   <= data_s1_r;
            data_s3_r   <= data_s2_r;
        end
    end

    // a change counts once stages two and three agree
    assign dclk_rise = (dclk_sync_r[1] == dclk_sync_r[2]) && dclk_sync_r[2] && !dclk_lvl_r;
    assign dclk_fall = (dclk_sync_r[1] == dclk_sync_r[2]) && !dclk_sync_r[2] && dclk_lvl_r;
    assign ref_edge  = (ref_sync_r[1] == ref_sync_r[2]) && (ref_sync_r[2] != ref_lvl_r);

    // filtered levels of the data and reference clocks
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dclk_lvl_r <= 1'b0;
            ref_lvl_r  <= 1'b0;
        end else begin
            if (dclk_sync_r[1] == dclk_sync_r[2])
                dclk_lvl_r <= dclk_sync_r[2];
            if (ref_sync_r[1] == ref_sync_r[2])
                ref_lvl_r <= ref_sync_r[2];
        end
    end

    // each domain advances its bridge on its own clock's edges
    assign dom_en[DOM_SYS] = 1'b1;                              // [RQ5]
    assign dom_en[DOM_REF] = ref_edge;
    assign dom_en[DOM_DIO] = dclk_rise | dclk_fall;             // [RQ7]
    assign dom_en[DOM_DGL] = (dclk_rise | dclk_fall) & rst_s2_r[DOM_DIO];

    // reset bridges: async assert, two-stage release per domain [RQ4] [RQ8] [RQ9]
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_s1_r <= 4'h0;
            rst_s2_r <= 4'h0;
        end else begin
            for (int d = 0; d < DOM_NUM; d++) begin
                if (dom_en[d]) begin
                    rst_s1_r[d] <= 1'b1;
                    rst_s2_r[d] <= rst_s1_r[d];
                end
            end
        end
    end

    // busy from reset until every bridge has released [RQ11] [RQ20]
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            o_reset_in_progress <= 1'b1;
        else
            o_reset_in_progress <= ~&rst_s2_r;
    end

    // reference pass-through only, held low while its domain is in reset
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_generator_primary_reference_clock <= 1'b0;
            o_generator_reference_select        <= 1'b0;
        end else begin
            o_generator_primary_reference_clock <= ref_lvl_r & rst_s2_r[DOM_REF]; // [RQ6] [RQ13]
            o_generator_reference_select        <= i_use_crystal_reference;       // [RQ14]
        end
    end

    // data clock watchdog: no edge for one slowest period flags loss
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            watch_r           <= 5'h0;
            o_data_clock_lost <= 1'b0;
        end else if (dclk_rise | dclk_fall) begin
            watch_r           <= 5'h0;
            o_data_clock_lost <= 1'b0;
        end else if (watch_r >= DCLK_WATCH_MAX) begin
            o_data_clock_lost <= 1'b1;                          // [RQ12]
        end else begin
            watch_r <= watch_r + 5'h1;
        end
    end

    // configuration sequencer in the system domain [RQ15] [RQ16]
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r              <= ST_WAIT;
            cfg_cnt_r            <= 6'h0;
            o_generator_rate_khz <= rate_khz(RATE_DEFAULT);
        end else begin
            case (state_r)
                ST_WAIT: begin
                    if (rst_s2_r[DOM_SYS]) begin
                        state_r   <= ST_ADC_CFG;
                        cfg_cnt_r <= 6'h0;
                    end
                end
                ST_ADC_CFG: begin
                    cfg_cnt_r <= cfg_cnt_r + 6'h1;
                    if (cfg_cnt_r == ADC_CFG_CYC - 6'h1) begin
                        state_r   <= ST_GEN_CFG;
                        cfg_cnt_r <= 6'h0;
                        // out-of-range selections fall back to the top preset [RQ3]
                        o_generator_rate_khz <= (32'(i_rate_select) < RATE_NUM) ?
                                                rate_khz(i_rate_select) : rate_khz(RATE_DEFAULT);
                    end
                end
                ST_GEN_CFG: begin
                    cfg_cnt_r <= cfg_cnt_r + 6'h1;
                    if (cfg_cnt_r == GEN_CFG_CYC - 6'h1)
                        state_r <= ST_DONE;
                end
                default: state_r <= ST_DONE;
            endcase
        end
    end

    assign o_adc_config_active       = (state_r == ST_ADC_CFG);
    assign o_generator_config_active = (state_r == ST_GEN_CFG);
    assign o_config_done             = (state_r == ST_DONE);

    // ddr split: rising edge holds channel a, falling edge completes the pair [RQ1]
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            raw_a_r  <= 14'h0;
            have_a_r <= 1'b0;
        end else if (!rst_s2_r[DOM_DIO]) begin
            have_a_r <= 1'b0;
        end else if (dclk_rise) begin
            raw_a_r  <= data_s3_r;
            have_a_r <= 1'b1;
        end else if (dclk_fall) begin
            have_a_r <= 1'b0;
        end
    end

    // a pair enters the buffer only while acquisition is enabled [RQ2] [RQ18]
    assign push_w = dclk_fall & have_a_r & rst_s2_r[DOM_DGL] & i_acquisition_enable;
    assign pop_w  = o_sample_valid & i_sample_ready;

    // two-entry buffer holding corrected pairs [RQ17]
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            buf_a_r[0] <= 14'h0;
            buf_a_r[1] <= 14'h0;
            buf_b_r[0] <= 14'h0;
            buf_b_r[1] <= 14'h0;
        end else if (push_w && (count_r != 2'h2)) begin
            buf_a_r[wr_ptr_r] <= calib(raw_a_r, i_gain_a, i_offset_a);
            buf_b_r[wr_ptr_r] <= calib(data_s3_r, i_gain_b, i_offset_b);
        end
    end

    // buffer pointers, fill count and sticky overrun on a full push with no pop in the same cycle
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_r  <= 1'b0;
            rd_ptr_r  <= 1'b0;
            count_r   <= 2'h0;
            o_overrun <= 1'b0;
        end else begin
            if (push_w && (count_r != 2'h2))
                wr_ptr_r <= ~wr_ptr_r;
            if (pop_w)
                rd_ptr_r <= ~rd_ptr_r;
            case ({push_w && (count_r != 2'h2), pop_w})
                2'b10:   count_r <= count_r + 2'h1;
                2'b01:   count_r <= count_r - 2'h1;
                default: count_r <= count_r;
            endcase
            if (push_w && (count_r == 2'h2) && !pop_w)
                o_overrun <= 1'b1;
        end
    end

    // outputs read straight from the buffer flops [RQ19]
    assign o_sample_valid = (count_r != 2'h0);
    assign o_channel_a    = buf_a_r[rd_ptr_r];
    assign o_channel_b    = buf_b_r[rd_ptr_r];

    // checks on reset release, capture, buffer and configuration
    a_busy_until_rel: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ20]
        !(&rst_s2_r) |=> o_reset_in_progress) else $error("busy dropped early");
    a_busy_fall_cause: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ11]
        $fell(o_reset_in_progress) |-> $past(&rst_s2_r))
        else $error("busy fell without release");
    a_sys_release: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ9]
        !rst_s2_r[DOM_SYS] |-> ##[1:SYS_REL_MAX] rst_s2_r[DOM_SYS])
        else $error("sys reset stuck");
    a_global_after_io: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ7]
        rst_s2_r[DOM_DGL] |-> rst_s2_r[DOM_DIO]) else $error("global domain left reset first");
    a_capture_rise: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ1]
        dclk_rise && rst_s2_r[DOM_DIO] |=> have_a_r && raw_a_r == $past(data_s3_r))
        else $error("channel a not captured");
    a_enable_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ2]
        $rose(o_sample_valid) |-> $past(i_acquisition_enable))
        else $error("sample without enable");
    a_stall_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ19]
        o_sample_valid && !i_sample_ready |=> o_sample_valid && $stable(o_channel_a)
        && $stable(o_channel_b)) else $error("stalled sample changed");
    a_unity_calib: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ17]
        push_w && count_r == 2'h0 && i_gain_b == GAIN_UNITY && i_offset_b == 14'h0
        |=> o_channel_b == $past(data_s3_r)) else $error("unity correction altered b");
    a_ref_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ6]
        !rst_s2_r[DOM_REF] |=> !o_generator_primary_reference_clock)
        else $error("reference forwarded in reset");
    a_adc_cfg_len: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ15]
        $rose(o_adc_config_active) |-> ##[1:ADC_WAIT_MAX] o_generator_config_active)
        else $error("adc configuration overran");
    a_rate_preset: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RQ3] [RQ16]
        o_config_done |-> o_generator_rate_khz inside {18'd50000, 18'd80000, 18'd100000,
        18'd110000, 18'd120000, 18'd122880, 18'd125000})
        else $error("rate not a preset");

    c_pair_pushed: cover property (@(posedge i_clk) disable iff (!i_rst_n) push_w);
    c_buffer_full: cover property (@(posedge i_clk) disable iff (!i_rst_n) count_r == 2'h2);
    c_config_done: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(o_config_done));

endmodule // adcf_top

`default_nettype wire
